// *** rtl/input_fault_diag_config_status.sv ***
// register bank for input fault diagnostics: live status, scan select and short thresholds
`include "fault_diag_cfg.svh"
module input_fault_diag_config_status (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // control port register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire fault_diag_pkg::reg_byte_t reg_addr,
  input wire fault_diag_pkg::reg_byte_t reg_wdata,
  output fault_diag_pkg::reg_byte_t reg_rdata,
  output logic reg_rvalid,
  // live fault conditions
  input wire logic upper_threshold_fault,
  input wire logic lower_threshold_fault,
  input wire logic voice_up_detect,
  input wire logic voice_down_detect,
  input wire logic bias_short,
  input wire logic bias_high_current,
  input wire logic bias_low_current,
  input wire logic bias_over_voltage,
  // input configuration of each channel
  input wire logic [1:0] chan_single_ended,
  input wire logic [1:0] chan_ac_coupled,
  // configured values for codes 10 to 13 of each field
  input wire fault_diag_pkg::millivolt_t pin_pair_custom_mv [4],
  input wire fault_diag_pkg::millivolt_t battery_custom_mv [4],
  input wire fault_diag_pkg::millivolt_t ground_custom_mv [4],
  input wire fault_diag_pkg::millivolt_t bias_custom_mv [4],
  // pins taken into the diagnostic scan, per channel
  output logic [1:0] positive_input_pin_scan,
  output logic [1:0] negative_input_pin_scan,
  // decoded thresholds
  output fault_diag_pkg::millivolt_t pin_pair_short_mv,
  output fault_diag_pkg::millivolt_t battery_short_mv,
  output fault_diag_pkg::millivolt_t ground_short_mv,
  output fault_diag_pkg::millivolt_t bias_short_mv
);
  import fault_diag_pkg::*;

  reg_byte_t input_scan_select;
  reg_byte_t terminal_battery_short_thresholds;
  reg_byte_t ground_bias_short_thresholds;
  reg_byte_t live_fault_event_status;
  reg_byte_t next_rdata;
  logic [1:0] chan_scan_on;
  logic single_ended_neg_pin_scan;
  logic ac_coupled_pin_scan;

  live_status_sync u_status (
    .core_clk(core_clk),
    .rstn(rstn),
    .upper_threshold_fault(upper_threshold_fault),
    .lower_threshold_fault(lower_threshold_fault),
    .voice_up_detect(voice_up_detect),
    .voice_down_detect(voice_down_detect),
    .bias_short(bias_short),
    .bias_high_current(bias_high_current),
    .bias_low_current(bias_low_current),
    .bias_over_voltage(bias_over_voltage),
    .status(live_fault_event_status)
  );

  // scan select: reserved low bits kept at zero whatever is written
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      input_scan_select <= `RST_INPUT_SCAN_SELECT;
    end else if (reg_wr && reg_addr == `OFS_INPUT_SCAN_SELECT) begin
      input_scan_select <= reg_wdata & `SCAN_SELECT_WRITABLE;
    end
  end

  // pin pair and battery thresholds
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      terminal_battery_short_thresholds <= `RST_TERMINAL_BATTERY_SHORT_THRESHOLDS;
    end else if (reg_wr && reg_addr == `OFS_TERMINAL_BATTERY_SHORT_THRESHOLDS) begin
      terminal_battery_short_thresholds <= reg_wdata;
    end
  end

  // ground and bias thresholds
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ground_bias_short_thresholds <= `RST_GROUND_BIAS_SHORT_THRESHOLDS;
    end else if (reg_wr && reg_addr == `OFS_GROUND_BIAS_SHORT_THRESHOLDS) begin
      ground_bias_short_thresholds <= reg_wdata;
    end
  end

  // read decode; unmapped offsets read zero
  always_comb begin
    if (reg_addr == `OFS_LIVE_FAULT_EVENT_STATUS) begin
      next_rdata = live_fault_event_status;
    end else if (reg_addr == `OFS_INPUT_SCAN_SELECT) begin
      next_rdata = input_scan_select;
    end else if (reg_addr == `OFS_TERMINAL_BATTERY_SHORT_THRESHOLDS) begin
      next_rdata = terminal_battery_short_thresholds;
    end else if (reg_addr == `OFS_GROUND_BIAS_SHORT_THRESHOLDS) begin
      next_rdata = ground_bias_short_thresholds;
    end else begin
      next_rdata = 8'h00;
    end
  end

  // read data held until the next read
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  assign chan_scan_on[0] = input_scan_select[`BIT_CHAN_ONE_SCAN_ON];
  assign chan_scan_on[1] = input_scan_select[`BIT_CHAN_TWO_SCAN_ON];
  assign single_ended_neg_pin_scan = input_scan_select[`BIT_SINGLE_ENDED_NEG_PIN_SCAN];
  assign ac_coupled_pin_scan = input_scan_select[`BIT_AC_COUPLED_PIN_SCAN];

  // per-channel pin inclusion; ac-coupled exclusion covers both pins
  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_scan
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          positive_input_pin_scan[ch] <= 1'b0;
          negative_input_pin_scan[ch] <= 1'b0;
        end else begin
          positive_input_pin_scan[ch] <= chan_scan_on[ch]
            && (!chan_ac_coupled[ch] || ac_coupled_pin_scan);
          negative_input_pin_scan[ch] <= chan_scan_on[ch]
            && (!chan_ac_coupled[ch] || ac_coupled_pin_scan)
            && (!chan_single_ended[ch] || single_ended_neg_pin_scan);
        end
      end
    end
  endgenerate

  threshold_decode #(.STEP_MV(`FINE_STEP_MV)) u_pin_pair (
    .core_clk(core_clk),
    .rstn(rstn),
    .code(terminal_battery_short_thresholds[7:4]),
    .custom_mv(pin_pair_custom_mv),
    .level_mv(pin_pair_short_mv)
  );

  threshold_decode #(.STEP_MV(`FINE_STEP_MV)) u_battery (
    .core_clk(core_clk),
    .rstn(rstn),
    .code(terminal_battery_short_thresholds[3:0]),
    .custom_mv(battery_custom_mv),
    .level_mv(battery_short_mv)
  );

  threshold_decode #(.STEP_MV(`COARSE_STEP_MV)) u_ground (
    .core_clk(core_clk),
    .rstn(rstn),
    .code(ground_bias_short_thresholds[7:4]),
    .custom_mv(ground_custom_mv),
    .level_mv(ground_short_mv)
  );

  threshold_decode #(.STEP_MV(`FINE_STEP_MV)) u_bias (
    .core_clk(core_clk),
    .rstn(rstn),
    .code(ground_bias_short_thresholds[3:0]),
    .custom_mv(bias_custom_mv),
    .level_mv(bias_short_mv)
  );
endmodule

// *** rtl/fault_diag_cfg.svh ***
// register offsets, field positions, reset values and threshold steps of the fault diagnostic bank
//
// Operation
// - status bit 7 is one while the analog input upper-threshold fault is present.
// - status bit 6 is one while the analog input lower-threshold fault is present.
// - status bit 5 shows voice power-up detect, bit 4 voice power-down detect.
// - status bit 3 is one while the bias output is shorted.
// - status bit 2 flags bias high current, bit 1 bias low current.
// - status bit 0 flags bias over-voltage.
// - status sits at 0x43, read-only live copy of conditions, resets to 0x00.
// - select bits 7 and 6 include channel one and two pins in scan; reset zero.
// - select bit 5 includes negative pins of single-ended channels in the scan.
// - select bit 4 includes both pins of ac-coupled channels in the scan.
// - pin pair short threshold is bits 7-4, 30 mV steps, codes 10-13 configurable.
// - battery short threshold is bits 3-0 with the same 30 mV table.
// - ground short threshold is bits 7-4 of second register, 60 mV steps.
// - bias short threshold is bits 3-0 of second register, 30 mV steps.
`ifndef FAULT_DIAG_CFG_SVH
`define FAULT_DIAG_CFG_SVH

`define OFS_LIVE_FAULT_EVENT_STATUS 8'h43
`define OFS_INPUT_SCAN_SELECT 8'h46
`define OFS_TERMINAL_BATTERY_SHORT_THRESHOLDS 8'h47
`define OFS_GROUND_BIAS_SHORT_THRESHOLDS 8'h48

`define RST_LIVE_FAULT_EVENT_STATUS 8'h00
`define RST_INPUT_SCAN_SELECT 8'h00
`define RST_TERMINAL_BATTERY_SHORT_THRESHOLDS 8'h37
`define RST_GROUND_BIAS_SHORT_THRESHOLDS 8'h87

`define BIT_UPPER_THRESHOLD 7
`define BIT_LOWER_THRESHOLD 6
`define BIT_VOICE_UP 5
`define BIT_VOICE_DOWN 4
`define BIT_BIAS_SHORT 3
`define BIT_BIAS_HIGH_CURRENT 2
`define BIT_BIAS_LOW_CURRENT 1
`define BIT_BIAS_OVER_VOLTAGE 0

`define BIT_CHAN_ONE_SCAN_ON 7
`define BIT_CHAN_TWO_SCAN_ON 6
`define BIT_SINGLE_ENDED_NEG_PIN_SCAN 5
`define BIT_AC_COUPLED_PIN_SCAN 4
`define SCAN_SELECT_WRITABLE 8'hf0

`define FINE_STEP_MV 10'h01e
`define COARSE_STEP_MV 10'h03c
`define CUSTOM_CODE_LO 4'ha
`define CUSTOM_CODE_HI 4'hd

`endif

// *** rtl/fault_diag_pkg.sv ***
// types shared by the fault diagnostic register bank
package fault_diag_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [9:0] millivolt_t;
  typedef logic [3:0] thr_code_t;
endpackage

// *** rtl/threshold_decode.sv ***
// maps a 4-bit short-detect code to its threshold in millivolts
`include "fault_diag_cfg.svh"
module threshold_decode #(
  parameter logic [9:0] STEP_MV = `FINE_STEP_MV
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // code and configured values for codes 10 to 13
  input wire fault_diag_pkg::thr_code_t code,
  input wire fault_diag_pkg::millivolt_t custom_mv [4],
  // decoded threshold
  output fault_diag_pkg::millivolt_t level_mv
);
  import fault_diag_pkg::*;

  millivolt_t next_level_mv;

  // linear table except for the configurable band
  always_comb begin
    if (code >= `CUSTOM_CODE_LO && code <= `CUSTOM_CODE_HI) begin
      next_level_mv = custom_mv[code[1:0] ^ 2'h2];
    end else begin
      next_level_mv = 10'(STEP_MV * code);
    end
  end

  // registered so the analog side sees a settled value
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      level_mv <= 10'h000;
    end else begin
      level_mv <= next_level_mv;
    end
  end
endmodule

// *** rtl/live_status_sync.sv ***
// samples live fault conditions into the read-only status word
`include "fault_diag_cfg.svh"
module live_status_sync (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // raw fault conditions
  input wire logic upper_threshold_fault,
  input wire logic lower_threshold_fault,
  input wire logic voice_up_detect,
  input wire logic voice_down_detect,
  input wire logic bias_short,
  input wire logic bias_high_current,
  input wire logic bias_low_current,
  input wire logic bias_over_voltage,
  // status word, live and not sticky
  output fault_diag_pkg::reg_byte_t status
);
  import fault_diag_pkg::*;

  reg_byte_t next_status;

  // bit placement of each fault
  always_comb begin
    next_status = `RST_LIVE_FAULT_EVENT_STATUS;
    next_status[`BIT_UPPER_THRESHOLD] = upper_threshold_fault;
    next_status[`BIT_LOWER_THRESHOLD] = lower_threshold_fault;
    next_status[`BIT_VOICE_UP] = voice_up_detect;
    next_status[`BIT_VOICE_DOWN] = voice_down_detect;
    next_status[`BIT_BIAS_SHORT] = bias_short;
    next_status[`BIT_BIAS_HIGH_CURRENT] = bias_high_current;
    next_status[`BIT_BIAS_LOW_CURRENT] = bias_low_current;
    next_status[`BIT_BIAS_OVER_VOLTAGE] = bias_over_voltage;
  end

  // follows conditions each cycle, so a cleared fault drops at the next clock edge
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      status <= `RST_LIVE_FAULT_EVENT_STATUS;
    end else begin
      status <= next_status;
    end
  end
endmodule

// *** testbench/input_fault_diag_config_status_assertions.sv ***
// checker for status, read timing, scan and threshold outputs of the bank
module input_fault_diag_config_status_assertions (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire fault_diag_pkg::reg_byte_t reg_addr,
  input wire fault_diag_pkg::reg_byte_t reg_wdata,
  input wire fault_diag_pkg::reg_byte_t reg_rdata,
  input wire logic reg_rvalid,
  // live faults
  input wire logic upper_threshold_fault,
  input wire logic lower_threshold_fault,
  input wire logic voice_up_detect,
  input wire logic voice_down_detect,
  input wire logic bias_short,
  input wire logic bias_high_current,
  input wire logic bias_low_current,
  input wire logic bias_over_voltage,
  // watched outputs
  input wire logic [1:0] positive_input_pin_scan,
  input wire fault_diag_pkg::millivolt_t pin_pair_short_mv,
  input wire fault_diag_pkg::millivolt_t ground_short_mv
);
  timeunit 1ns;
  timeprecision 1ns;
  import fault_diag_pkg::*;
  reg_byte_t live_now;
  logic status_rd;
  // faults in status bit order; answer lags the flop by one read cycle
  assign live_now = {upper_threshold_fault, lower_threshold_fault, voice_up_detect,
    voice_down_detect, bias_short, bias_high_current, bias_low_current, bias_over_voltage};
  assign status_rd = reg_rd && reg_addr == 8'h43;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  upper_lower_a: assert property (status_rd |=> reg_rdata[7:6] == $past(live_now[7:6], 2))
    else $error("status bits 7:6 wrong");
  voice_bits_a: assert property (status_rd |=> reg_rdata[5:4] == $past(live_now[5:4], 2))
    else $error("status bits 5:4 wrong");
  bias_fault_a: assert property (status_rd |=> reg_rdata[3:1] == $past(live_now[3:1], 2))
    else $error("status bits 3:1 wrong");
  over_volt_a: assert property (status_rd |=> reg_rdata[0] == $past(live_now[0], 2))
    else $error("status bit 0 wrong");
  rvalid_pulse_a: assert property (reg_rd ##1 !reg_rd |-> reg_rvalid ##1 !reg_rvalid)
    else $error("read answer not a one cycle pulse");
  // settle time: two idle edges after the write
  scan_off_a: assert property (reg_wr && reg_addr == 8'h46 && !reg_wdata[7] ##1 !reg_wr [*2]
    |=> !positive_input_pin_scan[0]) else $error("channel one scanned while off");
  pin_pair_thr_a: assert property (reg_wr && reg_addr == 8'h47 && reg_wdata[7:4] == 4'h1
    ##1 !reg_wr [*2] |=> pin_pair_short_mv == 10'h01e) else $error("pin pair code 1 wrong");
  ground_thr_a: assert property (reg_wr && reg_addr == 8'h48 && reg_wdata[7:4] == 4'h2
    ##1 !reg_wr [*2] |=> ground_short_mv == 10'h078) else $error("ground code 2 wrong");
  cover property (status_rd ##1 reg_rdata != 8'h00);
  cover property (reg_wr && reg_addr == 8'h46 && reg_wdata[7:6] == 2'b11);
  cover property (reg_wr && reg_addr == 8'h48 && reg_wdata[7:4] == 4'hf);
endmodule

bind input_fault_diag_config_status input_fault_diag_config_status_assertions i_chk (
  .core_clk(core_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .upper_threshold_fault(upper_threshold_fault), .lower_threshold_fault(lower_threshold_fault),
  .voice_up_detect(voice_up_detect), .voice_down_detect(voice_down_detect),
  .bias_short(bias_short), .bias_high_current(bias_high_current),
  .bias_low_current(bias_low_current), .bias_over_voltage(bias_over_voltage),
  .positive_input_pin_scan(positive_input_pin_scan), .pin_pair_short_mv(pin_pair_short_mv),
  .ground_short_mv(ground_short_mv));

// *** testbench/input_fault_diag_config_status_tb.sv ***
// self-checking bench for the fault diagnostic register bank
module input_fault_diag_config_status_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fault_diag_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  reg_byte_t reg_addr = 8'h00;
  reg_byte_t reg_wdata = 8'h00;
  reg_byte_t flt = 8'h00;
  logic [1:0] se = 2'b00;
  logic [1:0] ac = 2'b00;
  millivolt_t pp_cfg [4], bat_cfg [4], gnd_cfg [4], bias_cfg [4];
  reg_byte_t reg_rdata;
  logic reg_rvalid;
  logic [1:0] pos_scan, neg_scan;
  millivolt_t pp_mv, bat_mv, gnd_mv, bias_mv;
  int n_fail = 0;
  int checked = 0;

  input_fault_diag_config_status i_input_fault_diag_config_status (
    .core_clk(core_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .upper_threshold_fault(flt[7]), .lower_threshold_fault(flt[6]), .voice_up_detect(flt[5]),
    .voice_down_detect(flt[4]), .bias_short(flt[3]), .bias_high_current(flt[2]),
    .bias_low_current(flt[1]), .bias_over_voltage(flt[0]), .chan_single_ended(se),
    .chan_ac_coupled(ac), .pin_pair_custom_mv(pp_cfg), .battery_custom_mv(bat_cfg),
    .ground_custom_mv(gnd_cfg), .bias_custom_mv(bias_cfg), .positive_input_pin_scan(pos_scan),
    .negative_input_pin_scan(neg_scan), .pin_pair_short_mv(pp_mv), .battery_short_mv(bat_mv),
    .ground_short_mv(gnd_mv), .bias_short_mv(bias_mv));

  always #50 core_clk = ~core_clk;

  task automatic chk_byte(input reg_byte_t got, input reg_byte_t exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_mv(input millivolt_t got, input millivolt_t exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: threshold %h expected %h", $time, got, exp);
    end
  endtask

  // two idle edges after each write so settled outputs can be judged
  task automatic wr(input reg_byte_t a, input reg_byte_t d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge core_clk);
    #1 reg_wr = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  // answer judged in the cycle it stands, then one idle edge before the next request
  task automatic rd(input reg_byte_t a, input reg_byte_t exp);
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge core_clk);
    #1 reg_rd = 1'b0;
    chk_byte({7'h00, reg_rvalid}, 8'h01);
    chk_byte(reg_rdata, exp);
    @(posedge core_clk);
    #1 chk_byte({7'h00, reg_rvalid}, 8'h00);
    chk_byte(reg_rdata, exp);
  endtask

  // codes 10 to 13 take the configured table, the rest scale by the step
  function automatic millivolt_t exp_mv(input thr_code_t c, input millivolt_t step,
    input millivolt_t cfg [4]);
    return (c >= 4'ha && c <= 4'hd) ? cfg[c - 4'ha] : millivolt_t'(c * step);
  endfunction

  task automatic t_reset;
    rd(8'h43, 8'h00);
    rd(8'h46, 8'h00);
    rd(8'h47, 8'h37);
    rd(8'h48, 8'h87);
    chk_mv(pp_mv, 10'h05a);
    chk_mv(bat_mv, 10'h0d2);
    chk_mv(gnd_mv, 10'h1e0);
    chk_mv(bias_mv, 10'h0d2);
    chk_byte({4'h0, pos_scan, neg_scan}, 8'h00);
  endtask

  // walking one over the faults, then a write to the read-only word
  task automatic t_status;
    for (int i = 0; i < 8; i++) begin
      flt = 8'h01 << i;
      repeat (2) @(posedge core_clk);
      #1 rd(8'h43, 8'h01 << i);
    end
    flt = 8'h00;
    wr(8'h43, 8'hff);
    rd(8'h43, 8'h00);
    rd(8'h44, 8'h00);
  endtask

  task automatic t_scan;
    logic [1:0] on, pos;
    for (int k = 0; k < 32; k++) begin
      se = k[4] ? 2'b10 : 2'b01;
      ac = ~se;
      wr(8'h46, {k[3:0], 4'h0});
      rd(8'h46, {k[3:0], 4'h0});
      on = {k[2], k[3]};
      pos = on & (~ac | {2{k[0]}});
      chk_byte({4'h0, pos_scan, neg_scan}, {4'h0, pos, pos & (~se | {2{k[1]}})});
    end
  endtask

  task automatic t_thr;
    for (int c = 0; c < 16; c++) begin
      wr(8'h47, {c[3:0], 4'hf - c[3:0]});
      wr(8'h48, {4'hf - c[3:0], c[3:0]});
      chk_mv(pp_mv, exp_mv(c[3:0], 10'h01e, pp_cfg));
      chk_mv(bat_mv, exp_mv(4'hf - c[3:0], 10'h01e, bat_cfg));
      chk_mv(gnd_mv, exp_mv(4'hf - c[3:0], 10'h03c, gnd_cfg));
      chk_mv(bias_mv, exp_mv(c[3:0], 10'h01e, bias_cfg));
    end
  endtask

  task automatic end_of_test;
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // distinct configured values so a wrong table index shows
  initial begin
    for (int i = 0; i < 4; i++) begin
      pp_cfg[i] = 10'h100 + 10'(i);
      bat_cfg[i] = 10'h140 + 10'(i);
      gnd_cfg[i] = 10'h180 + 10'(i);
      bias_cfg[i] = 10'h1c0 + 10'(i);
    end
    repeat (12) @(posedge core_clk);
    #1 rstn = 1'b1;
    @(posedge core_clk);
    #1 t_reset();
    t_status();
    t_scan();
    t_thr();
    // reset in mid-run must restore every value the scenarios changed
    rstn = 1'b0;
    @(posedge core_clk);
    #1 rstn = 1'b1;
    @(posedge core_clk);
    #1 t_reset();
    end_of_test();
  end

  // watchdog well beyond the few hundred cycles the run needs
  initial begin
    #2000000;
    n_fail++;
    end_of_test();
  end
endmodule
